// ### hw/ubg_defs.svh
`ifndef UBG_DEFS_SVH
`define UBG_DEFS_SVH

// Register indices; the bus byte address is four times the index.
`define UBG_IDX_RXCTL 10'h018
`define UBG_IDX_TXCTL 10'h098
`define UBG_IDX_DIV 10'h099

// Transmit status/control field positions.
`define UBG_TX_MASTER_BIT 7
`define UBG_TX_SYNC_BIT 4
`define UBG_TX_HSPEED_BIT 2
`define UBG_TX_EMPTY_BIT 1

// Reset values and the bits that software may write.
`define UBG_TXCTL_RST 8'h02
`define UBG_RXCTL_RST 8'h00
`define UBG_DIV_RST 8'h00
`define UBG_TXCTL_WMASK 8'hF5
`define UBG_RXCTL_WMASK 8'hF8

// Last count of the prescaler: divide by 64, 16 and 4.
`define UBG_PRE_ASYNC_LOW 6'h3F
`define UBG_PRE_ASYNC_HIGH 6'h0F
`define UBG_PRE_SYNC 6'h03

`endif

// ### hw/ubg_pkg.sv
`default_nettype none

package ubg_pkg;

   typedef logic [7:0] ubg_byte_t;

   // Rate source selected by the transmit status/control bits.
   typedef enum logic [1:0] {
      UBG_ASYNC_LOW,
      UBG_ASYNC_HIGH,
      UBG_SYNC_MASTER,
      UBG_SYNC_SLAVE
   } ubg_mode_e;

endpackage

`default_nettype wire

// ### hw/ubg_majority.sv
`default_nettype none

module ubg_majority (
   input wire logic clk_i, // System clock.
   input wire logic rst_i, // Synchronous reset, active high.
   input wire logic sample_i, // One-cycle strobe that takes a sample.
   input wire logic pin_i, // Receive data pin level.
   output logic level_o // Majority of the last three samples.
);

   logic [2:0] samp_reg;
   logic [2:0] samp_next;

   // Two of three wins, so one noisy sample cannot flip the level.
   function automatic logic vote(input logic [2:0] s);
      return (s[0] & s[1]) | (s[1] & s[2]) | (s[0] & s[2]);
   endfunction

   // The line idles high, so the history starts as all ones.
   always_comb begin
      samp_next = sample_i ? {samp_reg[1:0], pin_i} : samp_reg;
   end

   // Sample history and the voted level.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         samp_reg <= 3'h7;
         level_o <= 1'b1;
      end else begin
         samp_reg <= samp_next;
         level_o <= vote(samp_next); // see RULE_09
      end
   end

   a_majority_vote: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_09
      (samp_reg == 3'h0) |-> !level_o)
      else $error("level not low on 3 low samples");

   a_majority_high: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_09
      sample_i && (samp_reg[1:0] == 2'h3) && pin_i |=> level_o)
      else $error("level not high on 3 high samples");

endmodule

`default_nettype wire

// ### hw/ubg_top.sv
// The Wishbone register port was chosen for this implementation.
`include "ubg_defs.svh"
`default_nettype none

// How it works
// RULE_01 - One dedicated 8-bit rate generator serves both async and sync modes.
// RULE_02 - The divisor register sets the period of a free-running 8-bit timer.
// RULE_03 - High-speed select changes the async rate and is ignored in sync mode.
// RULE_04 - Async rate is clock over 64(X+1), or over 16(X+1) at high speed.
// RULE_05 - Sync rate is clock over 4(X+1), with no high-speed variant.
// RULE_06 - Every divisor value 0 to 255 is used directly as X.
// RULE_07 - The formulas apply only when the generator makes the serial clock.
// RULE_08 - Writing the divisor clears the timer at once for a quick rate change.
// RULE_09 - The receive pin is sampled three times and decided by majority.
// RULE_10 - Transmit control resets to 0x02; sync select bit 4, high speed bit 2.
// RULE_11 - Receive control resets to zero, low bit unknown; divisor resets to zero.
// RULE_12 - Software may prefer high speed for slow rates to cut rate error.
// RULE_13 - The timer restarts after terminal count, one tick per X+1 prescaled clocks.

module ubg_top (
   input wire logic clk_i, // System clock, 25 MHz.
   input wire logic rst_i, // Synchronous reset, active high.
   input wire logic wb_cyc_i, // Wishbone cycle.
   input wire logic wb_stb_i, // Wishbone strobe.
   input wire logic wb_we_i, // Wishbone write enable.
   input wire logic [11:0] wb_adr_i, // Wishbone byte address.
   input wire logic [3:0] wb_sel_i, // Wishbone byte selects.
   input wire logic [31:0] wb_dat_i, // Wishbone write data.
   output logic [31:0] wb_dat_o, // Wishbone read data.
   output logic wb_ack_o, // Wishbone acknowledge.
   input wire logic rx_pin_i, // The receive_data_pin level.
   input wire logic tx_shift_empty_i, // Transmit shifter is empty.
   input wire logic [2:0] rx_status_i, // Receive framing, overrun, ninth bit.
   output logic baud_tick_o, // One-cycle pulse per bit time.
   output logic rx_level_o, // Majority-voted receive level.
   output var ubg_pkg::ubg_mode_e rate_mode_o, // Current rate source.
   output var ubg_pkg::ubg_byte_t tx_ctrl_o, // Transmit control bits.
   output var ubg_pkg::ubg_byte_t rx_ctrl_o // Receive control bits.
);
   import ubg_pkg::*;

   // Reset image of transmit control; the empty flag takes its bit from here.
   localparam ubg_byte_t TXCTL_RESET = `UBG_TXCTL_RST;

   ubg_byte_t txctl_reg;
   ubg_byte_t rxctl_reg;
   ubg_byte_t div_reg;
   logic empty_reg;
   logic [2:0] rx_stat_reg;
   logic [5:0] pre_reg;
   ubg_byte_t timer_reg;
   logic [31:0] rdata_next;
   logic bus_req;
   logic wr_now;
   logic hit_tx;
   logic hit_rc;
   logic hit_div;
   logic clear;
   logic run;
   logic pre_tick;
   logic [5:0] pre_last;
   ubg_mode_e mode_next;

   // Address match on the word index; the low two address bits are ignored.
   function automatic logic adr_is(input logic [11:0] a, input logic [9:0] idx);
      return a[11:2] == idx;
   endfunction

   // Rate source from the control bits; a sync slave takes its clock from outside.
   function automatic ubg_mode_e mode_of(input ubg_byte_t tx);
      if (tx[`UBG_TX_SYNC_BIT]) begin
         return tx[`UBG_TX_MASTER_BIT] ? UBG_SYNC_MASTER : UBG_SYNC_SLAVE; // see RULE_07
      end else if (tx[`UBG_TX_HSPEED_BIT]) begin
         return UBG_ASYNC_HIGH; // see RULE_03
      end else begin
         return UBG_ASYNC_LOW;
      end
   endfunction

   // Last prescaler count for a mode; high speed plays no part in sync mode.
   function automatic logic [5:0] pre_last_of(input ubg_mode_e m);
      case (m)
         UBG_ASYNC_LOW: return `UBG_PRE_ASYNC_LOW; // see RULE_04
         UBG_ASYNC_HIGH: return `UBG_PRE_ASYNC_HIGH; // see RULE_04
         default: return `UBG_PRE_SYNC; // see RULE_05
      endcase
   endfunction

   // Clock cycles per tick for a prescale and a divisor, at most 64 * 256.
   function automatic logic [14:0] period_of(input logic [5:0] pl, input ubg_byte_t d);
      logic [14:0] p;
      logic [14:0] x;
      p = {9'h000, pl} + 15'h0001;
      x = {7'h00, d} + 15'h0001;
      return 15'(p * x);
   endfunction

   // Bus decode: one request per ack, the register changes on the edge that raises ack.
   always_comb begin
      bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
      wr_now = bus_req & wb_we_i & wb_sel_i[0];
      hit_tx = adr_is(wb_adr_i, `UBG_IDX_TXCTL);
      hit_rc = adr_is(wb_adr_i, `UBG_IDX_RXCTL);
      hit_div = adr_is(wb_adr_i, `UBG_IDX_DIV);
   end

   // Read mux; unmapped addresses and the reserved bit read as zero.
   always_comb begin
      rdata_next = 32'h0000_0000;
      if (hit_tx) begin
         rdata_next[7:0] = txctl_reg;
         rdata_next[`UBG_TX_EMPTY_BIT] = empty_reg;
      end else if (hit_rc) begin
         rdata_next[7:0] = {rxctl_reg[7:3], rx_stat_reg};
      end else if (hit_div) begin
         rdata_next[7:0] = div_reg;
      end
   end

   // Acknowledge every request in the cycle after it arrives, mapped or not.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= bus_req;
         wb_dat_o <= bus_req ? rdata_next : 32'h0000_0000;
      end
   end

   // Transmit control; the reserved bit and the empty flag are never stored here.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         txctl_reg <= `UBG_TXCTL_RST & `UBG_TXCTL_WMASK; // see RULE_10
      end else if (wr_now && hit_tx) begin
         txctl_reg <= wb_dat_i[7:0] & `UBG_TXCTL_WMASK;
      end
   end

   // Receive control bits that software owns.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rxctl_reg <= `UBG_RXCTL_RST; // see RULE_11
      end else if (wr_now && hit_rc) begin
         rxctl_reg <= wb_dat_i[7:0] & `UBG_RXCTL_WMASK;
      end
   end

   // Divisor; any 8-bit value is legal and is used as it stands.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         div_reg <= `UBG_DIV_RST; // see RULE_11
      end else if (wr_now && hit_div) begin
         div_reg <= wb_dat_i[7:0]; // see RULE_06
      end
   end

   // Status from the shift logic, registered so a read sees a stable value.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         empty_reg <= TXCTL_RESET[`UBG_TX_EMPTY_BIT]; // see RULE_10
         rx_stat_reg <= 3'h0;
      end else begin
         empty_reg <= tx_shift_empty_i;
         rx_stat_reg <= rx_status_i;
      end
   end

   // Timer control. A control write also restarts it, so a mode change never
   // leaves a half-finished bit time at the old rate.
   always_comb begin
      mode_next = mode_of(txctl_reg);
      pre_last = pre_last_of(mode_next);
      run = mode_next != UBG_SYNC_SLAVE; // see RULE_07
      clear = wr_now && (hit_div || hit_tx); // see RULE_08
      pre_tick = run && (pre_reg == pre_last);
   end

   // Prescaler: divides the clock by 64, 16 or 4.
   always_ff @(posedge clk_i) begin
      if (rst_i || clear || !run || pre_tick) begin
         pre_reg <= 6'h00; // see RULE_08
      end else begin
         pre_reg <= pre_reg + 6'h01;
      end
   end

   // The 8-bit rate_timer counts prescaled clocks and restarts at the divisor.
   always_ff @(posedge clk_i) begin
      if (rst_i || clear || !run) begin
         timer_reg <= 8'h00; // see RULE_08
      end else if (pre_tick) begin
         if (timer_reg == div_reg) begin
            timer_reg <= 8'h00; // see RULE_13
         end else begin
            timer_reg <= timer_reg + 8'h01; // see RULE_02
         end
      end
   end

   // One tick per period; a clearing write suppresses a tick from the old count.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         baud_tick_o <= 1'b0;
      end else begin
         baud_tick_o <= pre_tick && (timer_reg == div_reg) && !clear; // see RULE_01
      end
   end

   // Control levels for the shift logic.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rate_mode_o <= UBG_ASYNC_LOW;
         tx_ctrl_o <= `UBG_TXCTL_RST & `UBG_TXCTL_WMASK;
         rx_ctrl_o <= `UBG_RXCTL_RST;
      end else begin
         rate_mode_o <= mode_next;
         tx_ctrl_o <= txctl_reg;
         rx_ctrl_o <= rxctl_reg;
      end
   end

   // The pin is sampled on each prescaled clock, X+1 times per bit time for divisor X.
   ubg_majority u_major (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .sample_i(pre_tick), // see RULE_09
      .pin_i(rx_pin_i),
      .level_o(rx_level_o)
   );

   // Helper: cycles since the last tick, valid only once a tick has been seen.
   logic [14:0] gap_reg;
   logic seen_reg;
   always_ff @(posedge clk_i) begin
      if (rst_i || clear || !run) begin
         gap_reg <= 15'h0000;
         seen_reg <= 1'b0;
      end else if (baud_tick_o) begin
         gap_reg <= 15'h0001;
         seen_reg <= 1'b1;
      end else begin
         gap_reg <= gap_reg + 15'h0001;
      end
   end

   // Checks on the rate timing, the register file and the bus replies.
   a_tick_period: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_04
      baud_tick_o && seen_reg && $stable(txctl_reg) && $stable(div_reg)
      |-> gap_reg == period_of(pre_last, div_reg))
      else $error("tick period differs from prescale times divisor plus one");

   a_sync_hs_ignored: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_05
      txctl_reg[`UBG_TX_SYNC_BIT] |-> pre_last == `UBG_PRE_SYNC)
      else $error("high speed select changed the sync prescale");

   a_async_hs_used: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_03
      !txctl_reg[`UBG_TX_SYNC_BIT] && txctl_reg[`UBG_TX_HSPEED_BIT]
      |-> pre_last == `UBG_PRE_ASYNC_HIGH)
      else $error("high speed prescale not used in async mode");

   a_write_clears: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_08
      wr_now && hit_div |=> (timer_reg == 8'h00) && (pre_reg == 6'h00) ##1 !baud_tick_o)
      else $error("divisor write did not clear the timer");

   a_ctrl_write_clears: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_08
      wr_now && hit_tx |=> (timer_reg == 8'h00) && (pre_reg == 6'h00))
      else $error("control write did not clear the timer");

   a_slave_silent: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_07
      (rate_mode_o == UBG_SYNC_SLAVE) && $past(rate_mode_o) == UBG_SYNC_SLAVE
      |-> !baud_tick_o)
      else $error("tick produced while the serial clock is external");

   a_timer_range: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_13
      $stable(div_reg) |-> timer_reg <= div_reg)
      else $error("timer ran past the divisor");

   a_tick_single: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_13
      baud_tick_o |=> !baud_tick_o)
      else $error("tick lasted more than one cycle");

   a_reset_values: assert property (@(posedge clk_i) // RULE_10
      rst_i |=> (txctl_reg == 8'h00) && (empty_reg == 1'b1) && (div_reg == 8'h00)
      && (rxctl_reg == 8'h00))
      else $error("register reset values wrong");

   a_ack_single: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_11
      wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");

   a_div_readback: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_06
      bus_req && !wb_we_i && hit_div |=> wb_ack_o && (wb_dat_o == {24'h000000, div_reg}))
      else $error("divisor read returned wrong data");

   a_rx_status_read: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_11
      bus_req && !wb_we_i && hit_rc
      |=> wb_ack_o && (wb_dat_o[2:0] == $past(rx_stat_reg)))
      else $error("receive status read returned wrong bits");

   a_reserved_zero: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_01
      wb_ack_o |-> (wb_dat_o[31:8] == 24'h000000))
      else $error("upper read bits not zero");

endmodule

`default_nettype wire

// ### verification/ubg_shift_model.sv
`default_nettype none

module ubg_shift_model (
   input wire logic clk_i, // System clock.
   input wire logic rst_i, // Synchronous reset, active high.
   input wire logic baud_tick_i, // Bit-time pulse from the generator.
   input wire logic send_i, // Starts a ten-bit transmit frame.
   input wire logic line_i, // Level to put on the receive pin.
   input wire logic [2:0] status_i, // Receive status to report.
   output logic rx_pin_o, // Receive data pin.
   output logic tx_empty_o, // Transmit shifter empty.
   output logic [2:0] rx_status_o // Receive status bits.
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] bits_left;

   // A frame lasts ten bit times, counted on the generator ticks alone.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bits_left <= 4'h0;
      end else if (send_i) begin
         bits_left <= 4'hA;
      end else if (baud_tick_i && bits_left != 4'h0) begin
         bits_left <= bits_left - 4'h1;
      end
   end

   // The shifter reads as empty only once its last bit time has passed.
   assign tx_empty_o = (bits_left == 4'h0);
   assign rx_pin_o = line_i;
   assign rx_status_o = status_i;
endmodule

`default_nettype wire

// ### verification/ubg_top_tb.sv
`default_nettype none

module ubg_top_tb;
   import ubg_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [11:0] adr = 12'h000;
   logic [31:0] wdat = 32'h0;
   logic [31:0] rdat;
   logic ack, rx_pin, tx_empty, tick, rx_level;
   logic [2:0] rx_status;
   logic send = 1'b0;
   logic line = 1'b1;
   logic [2:0] status = 3'h0;
   ubg_mode_e mode;
   ubg_byte_t tx_ctrl, rx_ctrl;
   int miscompares = 0;
   int check_count = 0;
   int cycles = 0;

   ubg_top i_ubg_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
      .wb_ack_o(ack), .rx_pin_i(rx_pin), .tx_shift_empty_i(tx_empty),
      .rx_status_i(rx_status), .baud_tick_o(tick), .rx_level_o(rx_level),
      .rate_mode_o(mode), .tx_ctrl_o(tx_ctrl), .rx_ctrl_o(rx_ctrl));

   ubg_shift_model i_ubg_shift_model (.clk_i(clk_i), .rst_i(rst_i), .baud_tick_i(tick),
      .send_i(send), .line_i(line), .status_i(status), .rx_pin_o(rx_pin),
      .tx_empty_o(tx_empty), .rx_status_o(rx_status));

   // Free-running 25 MHz clock.
   always #20 clk_i = ~clk_i;

   // Cuts a hang short; the longest test needs well under this many cycles.
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         miscompares++;
         conclude();
      end
   end

   task automatic conclude();
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask

   // One classic cycle; the request holds until ack is sampled high.
   task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d,
                      output logic [31:0] q);
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= {24'h0, d};
      do @(posedge clk_i); while (ack !== 1'b1);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask

   task automatic rd(input string what, input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] q;
      bus(1'b0, a, 8'h00, q);
      check(what, exp, q);
   endtask

   task automatic gap(output int n);
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (tick !== 1'b1 && n < 5000);
   endtask

   // Sets mode and divisor, then times the first tick and one full period.
   task automatic rate(input logic [7:0] tx, input logic [7:0] x, input int p,
                       input ubg_mode_e m);
      int n;
      logic [31:0] q;
      bus(1'b1, 12'h260, tx, q);
      bus(1'b1, 12'h264, x, q);
      check("rate mode", m, mode);
      gap(n);
      check("first tick", p * (x + 1), n);
      gap(n);
      check("tick period", p * (x + 1), n);
   endtask

   task automatic regs();
      logic [31:0] q;
      status <= 3'h5;
      bus(1'b1, 12'h264, 8'hA5, q);
      rd("divisor", 12'h264, 32'hA5);
      bus(1'b1, 12'h260, 8'hFF, q);
      rd("tx control", 12'h260, 32'hF7);
      check("tx control out", 32'hF5, tx_ctrl);
      bus(1'b1, 12'h060, 8'hFF, q);
      rd("rx control", 12'h060, 32'hFD);
      check("rx control out", 32'hF8, rx_ctrl);
      bus(1'b1, 12'h100, 8'hFF, q);
      rd("unmapped", 12'h100, 32'h0);
   endtask

   // A busy shifter clears the empty bit until its ten ticks are spent.
   task automatic shifter();
      logic [31:0] q;
      rate(8'h90, 8'h00, 4, UBG_SYNC_MASTER);
      @(posedge clk_i);
      send <= 1'b1;
      @(posedge clk_i);
      send <= 1'b0;
      rd("busy shifter", 12'h260, 32'h90);
      repeat (50) @(posedge clk_i);
      rd("idle shifter", 12'h260, 32'h92);
   endtask

   // Prescaler wraps every 4 cycles, so a 2-cycle glitch hits one sample.
   task automatic majority();
      int highs;
      highs = 0;
      line <= 1'b0;
      repeat (40) @(posedge clk_i);
      check("level low", 1'b0, rx_level);
      line <= 1'b1;
      repeat (2) @(posedge clk_i);
      line <= 1'b0;
      repeat (20) begin
         @(posedge clk_i);
         highs += (rx_level !== 1'b0);
      end
      check("glitch rejected", 0, highs);
      line <= 1'b1;
      repeat (40) @(posedge clk_i);
      check("level high", 1'b1, rx_level);
   endtask

   // External serial clock: the generator must stay silent.
   task automatic slave();
      int n;
      logic [31:0] q;
      n = 0;
      bus(1'b1, 12'h260, 8'h10, q);
      repeat (300) begin
         @(posedge clk_i);
         n += (tick === 1'b1);
      end
      check("slave ticks", 0, n);
      check("slave mode", UBG_SYNC_SLAVE, mode);
   endtask

   initial begin
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      check("level reset", 1'b1, rx_level);
      rd("tx reset", 12'h260, 32'h02);
      rd("rx reset", 12'h060, 32'h00);
      rd("div reset", 12'h264, 32'h00);
      rate(8'h00, 8'h00, 64, UBG_ASYNC_LOW);
      rate(8'h04, 8'h02, 16, UBG_ASYNC_HIGH);
      rate(8'h94, 8'h01, 4, UBG_SYNC_MASTER);
      rate(8'h94, 8'hFF, 4, UBG_SYNC_MASTER);
      regs();
      shifter();
      majority();
      slave();
      conclude();
   end
endmodule

`default_nettype wire
